// *** idt_pkg.sv ***
// Purpose: Shared constants and types for the instruction decode and timing block
// Assumes: Opcode map and field layout below are local to this core
// Notes:   Notes on behaviour follow
// Notes on behaviour
// - Single-word instruction is 24 bits; top 8 bits are the opcode.
// - Exactly three opcodes take two program words; all others take one.
// - Two-word op carries 48 bits; second word top 8 bits are zero.
// - A second word fetched alone executes as no operation.
// - Most ops take one cycle; true test or PC change adds a NOP cycle.
// - Branches, indirect call/jump, table ops and returns take two or three cycles.
// - Performed skip takes two cycles, three when skipped op is two words.
// - Double-word moves and all two-word ops take exactly two cycles.
// - Ops fall into word/byte, bit, literal and control classes.
// - Register word/byte ops decode base, second source and destination with modes.
// - File word/byte ops decode file address and file-or-register-zero destination.
// - Bit ops decode register or file target and literal or indirect bit position.
// - Literal moves decode a literal and a register or file target.
// - Literal arithmetic decodes base, literal, and destination only when separate.
// - Control ops decode a program address or a table access mode.
// - File address operand covers 0000h to 1FFFh in word/byte ops, 0000h to 03FFh in bit ops, 0000h to 00FFh in literal moves.
// - Register fields select one of sixteen working registers.
// - Ten-bit literal is limited to 255 in byte mode, 1023 in word mode.
package idt_pkg;
   //----------------------------------------------------------------
   // Opcodes of the control class
   //----------------------------------------------------------------
   localparam logic [7:0] OPC_NOP    = 8'h00; // Also any lone second word
   localparam logic [7:0] OPC_BRANCH = 8'h01; // branch_op
   localparam logic [7:0] OPC_BRAC   = 8'h02; // Computed branch
   localparam logic [7:0] OPC_ICALL  = 8'h03;
   localparam logic [7:0] OPC_IJMP   = 8'h04;
   localparam logic [7:0] OPC_TBLRD  = 8'h05;
   localparam logic [7:0] OPC_TBLWR  = 8'h06;
   localparam logic [7:0] OPC_RET    = 8'h07;
   localparam logic [7:0] OPC_RETI   = 8'h08; // interrupt_return_op
   localparam logic [7:0] OPC_BCOND  = 8'h09;
   localparam logic [7:0] OPC_SKIP   = 8'h0a;
   localparam logic [7:0] OPC_DMOV   = 8'h0b; // Single-word double move
   localparam logic [7:0] OPC_GOTO2  = 8'h10;
   localparam logic [7:0] OPC_CALL2  = 8'h11;
   localparam logic [7:0] OPC_DMOV2  = 8'h12;
   //----------------------------------------------------------------
   // Field positions inside a word
   //----------------------------------------------------------------
   localparam int P_OPC  = 16; // Opcode lsb, 8 bits
   localparam int P_CLS  = 22; // Class, 2 bits
   localparam int P_FMT  = 21; // File/move format select
   localparam int P_SUB  = 20; // Literal move to file
   localparam int P_SEP  = 17; // Literal arith separate dest
   localparam int P_BYTE = 16; // Byte mode
   localparam int P_BASE = 12;
   localparam int P_DMD  = 10;
   localparam int P_DST  = 6;
   localparam int P_SMD  = 4;
   localparam int P_SRC  = 0;
   localparam int P_FDST = 13; // 1 = file, 0 = working_reg_zero
   localparam int P_BIND = 15; // Bit position from base register
   localparam int P_BPOS = 11;
   localparam int P_LMV  = 4;  // 12-bit literal for register move
   localparam int P_LMF  = 8;  // 8-bit literal for file move
   //----------------------------------------------------------------
   // Cycle counts and limits
   //----------------------------------------------------------------
   localparam logic [1:0] CYC_ONE    = 2'h1;
   localparam logic [1:0] CYC_TWO    = 2'h2;
   localparam logic [1:0] CYC_BRANCH = 2'h2;
   localparam logic [1:0] CYC_INDIR  = 2'h2;
   localparam logic [1:0] CYC_TABLE  = 2'h2;
   localparam logic [1:0] CYC_RETURN = 2'h3;
   localparam logic [9:0] LIT_BYTE_MAX = 10'h0ff;
   localparam logic [1:0] RST_CYC    = 2'h1;

   typedef enum logic [1:0] {CLS_CTRL, CLS_WB, CLS_BIT, CLS_LIT} idt_class_t;

   typedef struct packed {
      idt_class_t  opClass;
      logic [7:0]  opcode;
      logic        byteMode;
      logic [3:0]  baseReg;     // base_source_reg
      logic [3:0]  srcReg;      // second_source_reg
      logic [1:0]  srcMode;
      logic [3:0]  dstReg;      // dest_reg
      logic [1:0]  dstMode;
      logic        hasDest;
      logic [12:0] fileAddr;
      logic        destIsFile;
      logic        targetIsFile;
      logic        bitIndirect;
      logic [3:0]  bitPos;
      logic [15:0] literal;
      logic        litOverRange;
      logic [22:0] progAddr;
      logic [1:0]  tableMode;
      logic        twoWord;
      logic        isNop;
      logic        isSkip;
   } idt_dec_t;
endpackage : idt_pkg

// *** idt_fields.sv ***
// Purpose: Splits one instruction word into class and operand fields
// Assumes: Purely combinational, fed straight from the fetch bus
// Notes:   Unused fields of a format read as zero
`timescale 1ns/1ps
module idt_fields (
   // Word in
   input  wire logic [23:0]      word,
   // Fields out
   output idt_pkg::idt_dec_t     dec
);
   //---------------------------------------------------------------
   // Field split
   //---------------------------------------------------------------
   logic [7:0] opc;
   assign opc = word[idt_pkg::P_OPC +: 8];

   // One case arm per class, its formats inside it; zeroed first so idle fields never toggle
   always_comb begin
      dec = '0;
      dec.opcode = opc;
      unique case (word[idt_pkg::P_CLS +: 2])
         2'h0: begin
            dec.opClass = idt_pkg::CLS_CTRL;
            dec.progAddr = {7'h00, word[15:0]};
            if (opc == idt_pkg::OPC_TBLRD || opc == idt_pkg::OPC_TBLWR) begin
               dec.tableMode = word[1:0];
            end
            dec.twoWord = (opc == idt_pkg::OPC_GOTO2) || (opc == idt_pkg::OPC_CALL2)
                       || (opc == idt_pkg::OPC_DMOV2);
            dec.isNop  = (opc == idt_pkg::OPC_NOP);
            dec.isSkip = (opc == idt_pkg::OPC_SKIP);
         end
         2'h1: begin
            dec.opClass  = idt_pkg::CLS_WB;
            dec.byteMode = word[idt_pkg::P_BYTE];
            if (word[idt_pkg::P_FMT]) begin
               dec.fileAddr   = word[12:0];
               dec.destIsFile = word[idt_pkg::P_FDST];
               dec.hasDest    = 1'b1;
            end else begin
               dec.baseReg = word[idt_pkg::P_BASE +: 4];
               dec.dstMode = word[idt_pkg::P_DMD +: 2];
               dec.dstReg  = word[idt_pkg::P_DST +: 4];
               dec.srcMode = word[idt_pkg::P_SMD +: 2];
               dec.srcReg  = word[idt_pkg::P_SRC +: 4];
               dec.hasDest = 1'b1;
            end
         end
         2'h2: begin
            dec.opClass      = idt_pkg::CLS_BIT;
            dec.targetIsFile = word[idt_pkg::P_FMT];
            dec.bitIndirect  = word[idt_pkg::P_BIND];
            dec.bitPos       = word[idt_pkg::P_BPOS +: 4];
            if (word[idt_pkg::P_FMT]) begin
               dec.fileAddr = {3'h0, word[9:0]};
            end else begin
               dec.srcReg  = word[idt_pkg::P_SRC +: 4];
               dec.srcMode = word[idt_pkg::P_SMD +: 2];
            end
         end
         default: begin
            dec.opClass  = idt_pkg::CLS_LIT;
            dec.byteMode = word[idt_pkg::P_BYTE];
            if (word[idt_pkg::P_FMT]) begin
               dec.hasDest = 1'b1;
               if (word[idt_pkg::P_SUB]) begin
                  dec.targetIsFile = 1'b1;
                  dec.literal  = {8'h00, word[idt_pkg::P_LMF +: 8]};
                  dec.fileAddr = {5'h00, word[7:0]};
               end else begin
                  dec.literal = {4'h0, word[idt_pkg::P_LMV +: 12]};
                  dec.dstReg  = word[idt_pkg::P_SRC +: 4];
               end
            end else begin
               dec.baseReg = word[idt_pkg::P_BASE +: 4];
               if (word[idt_pkg::P_SEP]) begin
                  dec.hasDest = 1'b1;
                  dec.dstMode = word[idt_pkg::P_DMD +: 2];
                  dec.dstReg  = word[idt_pkg::P_DST +: 4];
                  dec.literal = {11'h000, word[4:0]};
               end else begin
                  // Byte mode keeps only the low byte and flags the excess
                  dec.dstReg = word[idt_pkg::P_BASE +: 4];
                  dec.litOverRange = word[idt_pkg::P_BYTE]
                                  && (word[9:0] > idt_pkg::LIT_BYTE_MAX);
                  dec.literal = word[idt_pkg::P_BYTE] ? {8'h00, word[7:0]}
                                                      : {6'h00, word[9:0]};
               end
            end
         end
      endcase
   end
endmodule : idt_fields

// *** idt_decode.sv ***
// Purpose: Instruction decode and cycle timing for the core datapath
// Assumes: Fetch bus and condition inputs are on sys_clk
// Notes:   Inserted no-operation cycles show on nopSlot
`timescale 1ns/1ps
module idt_decode (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   // Fetch side
   input  wire logic              instrValid,
   input  wire logic [23:0]       instrWord,
   output logic                   fetchReady,
   // Conditions from the datapath
   input  wire logic              condTrue,
   input  wire logic              skipTrue,
   // Decoded operation out
   output logic                   opValid,
   output idt_pkg::idt_dec_t      opInfo,
   output logic [1:0]             opCycles,
   output logic                   nopSlot,
   output logic                   badSecond
);
   //---------------------------------------------------------------
   // Field split and sequencing state
   //---------------------------------------------------------------
   typedef enum logic [2:0] {ST_RUN, ST_WORD2, ST_STALL, ST_SKIP1, ST_SKIP2} idt_state_t;

   idt_state_t        state;
   idt_state_t        next_state;
   idt_pkg::idt_dec_t fieldDec;
   idt_pkg::idt_dec_t pendDec;
   logic [1:0]        stallCnt;
   logic [1:0]        cyc;
   logic              take;

   assign take = instrValid && fetchReady;

   idt_fields u_fields (
      .word (instrWord),
      .dec  (fieldDec)
   );

   // Cycle count of a single-word op
   always_comb begin
      unique case (fieldDec.opcode)
         idt_pkg::OPC_BRANCH, idt_pkg::OPC_BRAC: cyc = idt_pkg::CYC_BRANCH;
         idt_pkg::OPC_ICALL, idt_pkg::OPC_IJMP: cyc = idt_pkg::CYC_INDIR;
         idt_pkg::OPC_TBLRD, idt_pkg::OPC_TBLWR: cyc = idt_pkg::CYC_TABLE;
         idt_pkg::OPC_RET, idt_pkg::OPC_RETI:   cyc = idt_pkg::CYC_RETURN;
         idt_pkg::OPC_DMOV:  cyc = idt_pkg::CYC_TWO;
         idt_pkg::OPC_BCOND: cyc = condTrue ? idt_pkg::CYC_TWO : idt_pkg::CYC_ONE;
         idt_pkg::OPC_SKIP:  cyc = skipTrue ? idt_pkg::CYC_TWO : idt_pkg::CYC_ONE;
         default:            cyc = idt_pkg::CYC_ONE;
      endcase
      if (fieldDec.opClass != idt_pkg::CLS_CTRL) begin
         cyc = idt_pkg::CYC_ONE;
      end
   end

   //---------------------------------------------------------------
   // Sequencer
   //---------------------------------------------------------------
   // Skips squash following words instead of stalling, so the second
   // word of a squashed two-word op is swallowed too
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RUN: begin
            if (take) begin
               if (fieldDec.twoWord) begin
                  next_state = ST_WORD2;
               end else if (fieldDec.isSkip && skipTrue) begin
                  next_state = ST_SKIP1;
               end else if (cyc != idt_pkg::CYC_ONE) begin
                  next_state = ST_STALL;
               end
            end
         end
         ST_WORD2: if (take) next_state = ST_RUN;
         ST_STALL: if (stallCnt == idt_pkg::CYC_ONE) next_state = ST_RUN;
         ST_SKIP1: begin
            if (take) begin
               next_state = fieldDec.twoWord ? ST_SKIP2 : ST_RUN;
            end
         end
         ST_SKIP2: if (take) next_state = ST_RUN;
      endcase
   end

   // State register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   // Remaining stall cycles after a multi-cycle single-word op
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stallCnt <= 2'h0;
      end else if (state == ST_RUN && take) begin
         stallCnt <= cyc - idt_pkg::CYC_ONE;
      end else if (state == ST_STALL) begin
         stallCnt <= stallCnt - idt_pkg::CYC_ONE;
      end
   end

   // Fetch is held off only while a stall is pending
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fetchReady <= 1'b1;
      end else begin
         fetchReady <= (next_state != ST_STALL);
      end
   end

   // First word of a two-word op is parked until its partner arrives
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pendDec <= '0;
      end else if (state == ST_RUN && take && fieldDec.twoWord) begin
         pendDec <= fieldDec;
      end
   end

   //---------------------------------------------------------------
   // Decoded outputs
   //---------------------------------------------------------------
   // Op issue; a lone word with a zero opcode issues as a no-operation
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         opValid  <= 1'b0;
         opInfo   <= '0;
         opCycles <= idt_pkg::RST_CYC;
      end else begin
         opValid <= 1'b0;
         if (take && state == ST_RUN && !fieldDec.twoWord) begin
            opValid  <= 1'b1;
            opInfo   <= fieldDec;
            opCycles <= cyc;
         end else if (take && state == ST_WORD2) begin
            opValid  <= 1'b1;
            opInfo   <= pendDec;
            opInfo.progAddr <= {instrWord[6:0], pendDec.progAddr[15:0]};
            opCycles <= idt_pkg::CYC_TWO;
         end
      end
   end

   // Inserted no-operation cycles of stalls and skips
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         nopSlot <= 1'b0;
      end else begin
         nopSlot <= (state == ST_STALL)
                 || (take && (state == ST_SKIP1 || state == ST_SKIP2));
      end
   end

   // Second word must carry a zero upper byte; flagged, not refused
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         badSecond <= 1'b0;
      end else begin
         badSecond <= take && (state == ST_WORD2)
                   && (instrWord[idt_pkg::P_OPC +: 8] != 8'h00);
      end
   end

   //---------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   AST_RET_STALL: assert property (
      opValid && opCycles == 2'h3 |-> !fetchReady && !nopSlot ##1 !fetchReady && nopSlot
                                      ##1 fetchReady && nopSlot ##1 !nopSlot)
      else $error("return did not stall two cycles");
   AST_TWO_CYC: assert property (
      opValid && opInfo.twoWord |-> opCycles == 2'h2 && fetchReady)
      else $error("two-word op not two cycles");
   AST_EXCL: assert property (
      !(opValid && nopSlot))
      else $error("op and nop slot together");
   AST_CLASS: assert property (
      opValid |-> opInfo.opClass == idt_pkg::idt_class_t'(opInfo.opcode[7:6]))
      else $error("class does not follow opcode");
   AST_LIT_BYTE: assert property (
      opValid && opInfo.opClass == idt_pkg::CLS_LIT && opInfo.byteMode
      |-> opInfo.literal[15:8] == 8'h00)
      else $error("byte literal above 255");
   AST_SKIP_SQUASH: assert property (
      state == ST_SKIP1 && take |=> nopSlot && !opValid)
      else $error("skipped word not squashed");
   AST_LONE_NOP: assert property (
      state == ST_RUN && take && instrWord[23:16] == 8'h00 |=> opValid && opInfo.isNop
                                                              && opCycles == 2'h1)
      else $error("lone second word not a nop");
   AST_COND: assert property (
      state == ST_RUN && take && instrWord[23:16] == idt_pkg::OPC_BCOND
      |=> opCycles == ($past(condTrue) ? 2'h2 : 2'h1))
      else $error("conditional branch cycles wrong");
   AST_PAIR: assert property (
      state == ST_RUN && take && fieldDec.twoWord |=> !opValid && state == ST_WORD2)
      else $error("two-word op issued early");
   AST_STALL_ONE: assert property (
      opValid && opCycles == 2'h2 && !opInfo.twoWord && !opInfo.isSkip
      |-> !fetchReady ##1 fetchReady && nopSlot ##1 !nopSlot)
      else $error("two-cycle op did not stall once");
   AST_SKIP2_SQUASH: assert property (
      state == ST_SKIP2 && take |=> nopSlot && !opValid)
      else $error("partner of skipped word not squashed");
   AST_BAD_SECOND: assert property (
      state == ST_WORD2 && take && instrWord[23:16] != 8'h00 |=> badSecond && opValid)
      else $error("nonzero second word not flagged");

   COV_TWO_WORD: cover property (state == ST_WORD2 && take);
   COV_SKIP_TWO: cover property (state == ST_SKIP2 && take);
   COV_RETURN:   cover property (opValid && opCycles == 2'h3);
   COV_STALL:    cover property (state == ST_STALL && stallCnt == 2'h2);
endmodule : idt_decode

// *** idt_prog_mem.sv ***
// Purpose: Program memory model offering instruction words to the decoder
// Assumes: Bench queues words with their condition flags
// Notes:   Slow mode leaves one idle cycle after every taken word
`timescale 1ns/1ps
module idt_prog_mem (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Fetch handshake
   input  wire logic        fetchReady,
   input  wire logic        slowMode,
   output logic             instrValid,
   output logic [23:0]      instrWord,
   // Conditions travelling with each word
   output logic             condTrue,
   output logic             skipTrue
);
   logic [25:0] wordQ[$];   // {cond, skip, word}
   logic        taken;

   //------------------------------------------------------------
   // Bench access
   //------------------------------------------------------------
   task automatic push(input logic [23:0] w, input logic c, input logic s);
      wordQ.push_back({c, s, w});
   endtask : push

   function automatic int pending();
      return wordQ.size();
   endfunction : pending

   initial begin
      instrValid = 1'b0;
      instrWord  = 24'h5a5a5a;
      condTrue   = 1'b0;
      skipTrue   = 1'b0;
      taken      = 1'b0;
   end

   // Remember whether the rising edge took the offered word
   always @(posedge sys_clk) taken <= instrValid && fetchReady;

   // Offer on the falling edge; a refused word is held, never withdrawn
   always @(negedge sys_clk) begin
      if (taken) void'(wordQ.pop_front());
      if (instrValid && !taken) begin
         instrValid <= 1'b1;
      end else if (rst_n && wordQ.size() > 0 && !(slowMode && taken)) begin
         instrValid <= 1'b1;
         {condTrue, skipTrue, instrWord} <= wordQ[0];
      end else begin
         // Idle lines keep moving so a stale word is never mistaken for data
         instrValid <= 1'b0;
         instrWord  <= ~instrWord;
         condTrue   <= ~condTrue;
         skipTrue   <= ~skipTrue;
      end
   end
endmodule : idt_prog_mem

// *** test_instruction_decode_timing.sv ***
// Purpose: Self-checking bench for the decode and timing block
// Assumes: Opcode map and field layout of the shared package
// Notes:   Each scenario drains the pipe before it judges the counts
`timescale 1ns/1ps
module test_instruction_decode_timing;
   logic               sys_clk, rst_n, slowMode;
   logic               fetchReady, instrValid, condTrue, skipTrue;
   logic [23:0]        instrWord;
   logic               opValid, nopSlot, badSecond;
   logic [1:0]         opCycles, lastCyc;
   idt_pkg::idt_dec_t  opInfo, lastInfo;
   int                 bad_count, checks_done, opSeen, nopSeen, badSeen;

   initial sys_clk = 1'b0;
   always #12.5 sys_clk = ~sys_clk;

   idt_decode dut (.sys_clk(sys_clk), .rst_n(rst_n), .instrValid(instrValid),
      .instrWord(instrWord), .fetchReady(fetchReady), .condTrue(condTrue),
      .skipTrue(skipTrue), .opValid(opValid), .opInfo(opInfo),
      .opCycles(opCycles), .nopSlot(nopSlot), .badSecond(badSecond));
   idt_prog_mem mem (.sys_clk(sys_clk), .rst_n(rst_n), .fetchReady(fetchReady),
      .slowMode(slowMode), .instrValid(instrValid), .instrWord(instrWord),
      .condTrue(condTrue), .skipTrue(skipTrue));

   //------------------------------------------------------------
   // Monitor: pulses last one cycle, so count them mid-cycle
   //------------------------------------------------------------
   always @(negedge sys_clk) begin
      if (opValid === 1'b1) begin
         opSeen++;
         lastInfo = opInfo;
         lastCyc  = opCycles;
      end
      if (nopSlot === 1'b1) nopSeen++;
      if (badSecond === 1'b1) badSeen++;
   end

   //------------------------------------------------------------
   // Shared tasks
   //------------------------------------------------------------
   task automatic check(input string what, input logic [95:0] exp, input logic [95:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test

   // Wait, bounded, for queue empty and no stall, then judge the counts
   task automatic settle(input int expOps, input int expNops);
      int n;
      n = 0;
      while ((mem.pending() != 0 || fetchReady !== 1'b1) && n < 60) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 60) begin
         check("drain", 0, 1);
         stop_test();
      end
      repeat (4) @(negedge sys_clk);
      check("ops", expOps, opSeen);
      check("nops", expNops, nopSeen);
      opSeen  = 0;
      nopSeen = 0;
   endtask : settle

   //------------------------------------------------------------
   // Scenarios
   //------------------------------------------------------------
   task automatic t_reset();
      rst_n    = 1'b0;
      slowMode = 1'b0;
      repeat (2) @(negedge sys_clk);
      check("ready", 1'b1, fetchReady);
      check("valid", 1'b0, opValid);
      check("cycles", 2'h1, opCycles);
      check("info", '0, opInfo);
      rst_n = 1'b1;
      $display("test reset done");
   endtask : t_reset

   task automatic t_regops();
      mem.push({8'h40, 16'ha6e5}, 1'b0, 1'b0);
      settle(1, 0);
      check("class", idt_pkg::CLS_WB, lastInfo.opClass);
      check("opcode", 8'h40, lastInfo.opcode);
      check("base", 4'ha, lastInfo.baseReg);
      check("dmode", 2'h1, lastInfo.dstMode);
      check("dst", 4'hb, lastInfo.dstReg);
      check("smode", 2'h2, lastInfo.srcMode);
      check("src", 4'h5, lastInfo.srcReg);
      check("cycles", 2'h1, lastCyc);
      slowMode = 1'b1;
      mem.push({8'h41, 16'h0000}, 1'b0, 1'b0);
      mem.push({8'h41, 16'hffff}, 1'b0, 1'b0);
      settle(2, 0);
      slowMode = 1'b0;
      check("byte", 1'b1, lastInfo.byteMode);
      check("src", 4'hf, lastInfo.srcReg);
      check("dst", 4'hf, lastInfo.dstReg);
      $display("test regops done");
   endtask : t_regops

   task automatic t_fileops();
      mem.push({8'h60, 16'h1fff}, 1'b0, 1'b0);
      settle(1, 0);
      check("faddr", 13'h1fff, lastInfo.fileAddr);
      check("tofile", 1'b0, lastInfo.destIsFile);
      mem.push({8'h60, 16'h2000}, 1'b0, 1'b0);
      settle(1, 0);
      check("faddr", 13'h0000, lastInfo.fileAddr);
      check("tofile", 1'b1, lastInfo.destIsFile);
      $display("test fileops done");
   endtask : t_fileops

   task automatic t_bitlit();
      mem.push({8'h80, 16'hc800}, 1'b0, 1'b0);
      settle(1, 0);
      check("class", idt_pkg::CLS_BIT, lastInfo.opClass);
      check("indir", 1'b1, lastInfo.bitIndirect);
      check("bitpos", 4'h9, lastInfo.bitPos);
      mem.push({8'ha0, 16'h7800}, 1'b0, 1'b0);
      settle(1, 0);
      check("indir", 1'b0, lastInfo.bitIndirect);
      check("bitpos", 4'hf, lastInfo.bitPos);
      check("target", 1'b1, lastInfo.targetIsFile);
      mem.push({8'he0, 16'habc3}, 1'b0, 1'b0);
      settle(1, 0);
      check("class", idt_pkg::CLS_LIT, lastInfo.opClass);
      check("literal", 16'h0abc, lastInfo.literal);
      check("target", 1'b0, lastInfo.targetIsFile);
      mem.push({8'hc1, 16'h73ff}, 1'b0, 1'b0);
      settle(1, 0);
      check("base", 4'h7, lastInfo.baseReg);
      check("literal", 16'h00ff, lastInfo.literal);
      check("over", 1'b1, lastInfo.litOverRange);
      check("hasdest", 1'b0, lastInfo.hasDest);
      mem.push({8'hc2, 16'h5a93}, 1'b0, 1'b0);
      settle(1, 0);
      check("literal", 16'h0013, lastInfo.literal);
      check("dst", 4'ha, lastInfo.dstReg);
      check("dmode", 2'h2, lastInfo.dstMode);
      check("hasdest", 1'b1, lastInfo.hasDest);
      $display("test bitlit done");
   endtask : t_bitlit

   // Every stalling control opcode: stall slots are cycles minus one
   task automatic t_control();
      logic [7:0] ops [9] = '{idt_pkg::OPC_BRANCH, idt_pkg::OPC_BRAC, idt_pkg::OPC_ICALL,
         idt_pkg::OPC_IJMP, idt_pkg::OPC_TBLRD, idt_pkg::OPC_TBLWR, idt_pkg::OPC_RET,
         idt_pkg::OPC_RETI, idt_pkg::OPC_DMOV};
      logic [1:0] cyc [9] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2};
      for (int i = 0; i < 9; i++) begin
         mem.push({ops[i], 16'h0000}, 1'b0, 1'b0);
         settle(1, int'(cyc[i]) - 1);
         check("cycles", cyc[i], lastCyc);
         check("class", idt_pkg::CLS_CTRL, lastInfo.opClass);
      end
      mem.push({idt_pkg::OPC_BCOND, 16'h0000}, 1'b0, 1'b0);
      settle(1, 0);
      check("cycles", 2'h1, lastCyc);
      mem.push({idt_pkg::OPC_BCOND, 16'h0000}, 1'b1, 1'b0);
      settle(1, 1);
      check("cycles", 2'h2, lastCyc);
      mem.push({idt_pkg::OPC_TBLWR, 16'h0002}, 1'b0, 1'b0);
      settle(1, 1);
      check("tmode", 2'h2, lastInfo.tableMode);
      check("paddr", 23'h000002, lastInfo.progAddr);
      $display("test control done");
   endtask : t_control

   task automatic t_twoword();
      logic [7:0] ops [3] = '{idt_pkg::OPC_GOTO2, idt_pkg::OPC_CALL2, idt_pkg::OPC_DMOV2};
      for (int i = 0; i < 3; i++) begin
         mem.push({ops[i], 16'h1234}, 1'b0, 1'b0);
         mem.push({8'h00, 16'h0055}, 1'b0, 1'b0);
         settle(1, 0);
         check("cycles", 2'h2, lastCyc);
         check("twoword", 1'b1, lastInfo.twoWord);
         check("paddr", 23'h551234, lastInfo.progAddr);
      end
      check("bad", 0, badSeen);
      mem.push({idt_pkg::OPC_GOTO2, 16'h0000}, 1'b0, 1'b0);
      mem.push({8'h80, 16'h0000}, 1'b0, 1'b0);
      settle(1, 0);
      check("bad", 1, badSeen);
      mem.push({8'h00, 16'h0055}, 1'b0, 1'b0);
      settle(1, 0);
      check("isnop", 1'b1, lastInfo.isNop);
      check("cycles", 2'h1, lastCyc);
      $display("test twoword done");
   endtask : t_twoword

   task automatic t_skip();
      mem.push({idt_pkg::OPC_SKIP, 16'h0000}, 1'b0, 1'b1);
      mem.push({8'h40, 16'h0000}, 1'b0, 1'b0);
      settle(1, 1);
      check("cycles", 2'h2, lastCyc);
      check("isskip", 1'b1, lastInfo.isSkip);
      mem.push({idt_pkg::OPC_SKIP, 16'h0000}, 1'b0, 1'b1);
      mem.push({idt_pkg::OPC_CALL2, 16'h0000}, 1'b0, 1'b0);
      mem.push({8'h00, 16'h0000}, 1'b0, 1'b0);
      settle(1, 2);
      mem.push({idt_pkg::OPC_SKIP, 16'h0000}, 1'b0, 1'b0);
      settle(1, 0);
      check("cycles", 2'h1, lastCyc);
      $display("test skip done");
   endtask : t_skip

   initial begin
      bad_count   = 0;
      checks_done = 0;
      opSeen      = 0;
      nopSeen     = 0;
      badSeen     = 0;
      t_reset();
      t_regops();
      t_fileops();
      t_bitlit();
      t_control();
      t_twoword();
      t_skip();
      stop_test();
   end
endmodule : test_instruction_decode_timing
